// ==== rtl/tw_timer_family.sv ====
// timer family: full timer, basic timer, two watchdogs, tick counter, Wishbone slave
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tw_timer_family #(
  parameter int CNT_W  = 32,
  parameter int NUM_CH = 4,
  parameter int WW_DIV = 4096
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    dbg_halt_i,
  input  wire logic [NUM_CH-1:0]       ch_in_i,
  output logic      [NUM_CH-1:0]       ch_out_o,
  output logic      [2:0]              chn_out_o,
  input  wire logic                    trig_in_i,
  output logic                         trgo_o,
  output logic                         dma_req_o,
  output logic                         dac_trig_o,
  output logic                         bdma_req_o,
  input  wire logic                    lsi_i,
  input  wire logic                    iwdg_hw_start_i,
  output logic                         dev_reset_o,
  output logic                         wwdg_ewi_o,
  output logic                         tick_irq_o
);
  import tw_pkg::*;

  generate
    if ((CNT_W != 16 && CNT_W != 32) || !(NUM_CH == 1 || NUM_CH == 2 || NUM_CH == 4)
        || WW_DIV < 2) begin : g_chk
      $error("tw_timer_family: unsupported parameter value");
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // ---------------- bus slave ----------------
  logic        wr;
  logic [31:0] rdata;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  function automatic logic wr_at(input logic [7:0] a);
    return wr && (wb_adr_i == a);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
        wb_dat_o <= rdata;
    end
  end
  logic rd_kctl;
  assign rd_kctl = wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o & (wb_adr_i == A_KCTL);

  // ---------------- pin synchronisers ----------------
  logic [NUM_CH-1:0] ch_s1, ch_s2, ch_s3;
  logic              lsi_s1, lsi_s2, lsi_s3;
  logic              strap_s1, strap_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_s1 <= '0; ch_s2 <= '0; ch_s3 <= '0;
      lsi_s1 <= 1'b0; lsi_s2 <= 1'b0; lsi_s3 <= 1'b0;
      strap_s1 <= 1'b0; strap_s2 <= 1'b0;
    end else begin
      ch_s1 <= ch_in_i; ch_s2 <= ch_s1; ch_s3 <= ch_s2;
      lsi_s1 <= lsi_i; lsi_s2 <= lsi_s1; lsi_s3 <= lsi_s2;
      strap_s1 <= iwdg_hw_start_i; strap_s2 <= strap_s1;
    end
  end

  // ---------------- full-featured timer ----------------
  logic [TCTL_W-1:0]   tctl;
  logic [15:0]         tpsc, psc_cnt;
  logic [CNT_W-1:0]    tarr, cnt, next_cnt;
  logic [2*NUM_CH-1:0] tmode;
  logic [8:0]          tdt;
  logic                tie, cdn, next_cdn, upd, step, run, enc_dn, any_opp;
  logic [NUM_CH:0]     tstat;
  logic [NUM_CH-1:0]   cap_ev, cmp_ev, oc_ref;
  logic [CNT_W-1:0]    ccr [NUM_CH];

  assign run = tctl[B_EN] && !(tctl[B_FRZ] && dbg_halt_i);

  always_comb begin
    any_opp = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      if (tmode[2*i +: 2] == CM_OPP) any_opp = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tctl <= '0; tpsc <= 16'h0; tarr <= '1; tmode <= '0; tdt <= 9'h0; tie <= 1'b0;
    end else begin
      if (wr_at(A_TCTL)) tctl <= TCTL_W'(merge(32'(tctl), wb_dat_i, wb_sel_i));
      else if (upd && (tctl[B_OPM] || any_opp)) tctl[B_EN] <= 1'b0;
      if (wr_at(A_TPSC)) tpsc <= 16'(merge(32'(tpsc), wb_dat_i, wb_sel_i));
      if (wr_at(A_TARR)) tarr <= CNT_W'(merge(32'(tarr), wb_dat_i, wb_sel_i));
      if (wr_at(A_TMODE)) tmode <= (2*NUM_CH)'(merge(32'(tmode), wb_dat_i, wb_sel_i));
      if (wr_at(A_TDT)) tdt <= 9'(merge(32'(tdt), wb_dat_i, wb_sel_i));
      if (wr_at(A_TIE)) tie <= wb_dat_i[B_DMA] & wb_sel_i[0];
    end
  end

  // prescaler, or encoder edges when encoder mode is on
  logic psc_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) psc_cnt <= 16'h0;
    else if (!run) psc_cnt <= psc_cnt;
    else if (psc_cnt >= tpsc) psc_cnt <= 16'h0;
    else psc_cnt <= psc_cnt + 16'h1;
  end
  assign psc_tick = run && (psc_cnt >= tpsc);
  // quadrature: count on each edge of input 0, direction from input 1
  assign step   = tctl[B_ENC] ? (run && (ch_s2[0] != ch_s3[0])) : psc_tick;
  assign enc_dn = (NUM_CH > 1) ? (ch_s2[0] ~^ ch_s2[NUM_CH > 1 ? 1 : 0]) : 1'b0;

  always_comb begin
    next_cnt = cnt;
    next_cdn = tctl[B_CMS] ? cdn : 1'b0;
    upd      = 1'b0;
    if (tctl[B_SLV] && trig_in_i) begin
      next_cnt = '0;
      upd      = 1'b1;
    end else if (step) begin
      if (tctl[B_CMS] && !tctl[B_ENC]) begin
        if (!cdn) begin
          if (cnt >= tarr) begin
            next_cdn = 1'b1;
            next_cnt = (tarr == '0) ? '0 : cnt - CNT_W'(1);
            upd      = 1'b1;
          end else next_cnt = cnt + CNT_W'(1);
        end else begin
          if (cnt == '0) begin
            next_cdn = 1'b0;
            next_cnt = (tarr == '0) ? '0 : CNT_W'(1);
            upd      = 1'b1;
          end else next_cnt = cnt - CNT_W'(1);
        end
      end else if (tctl[B_ENC] ? enc_dn : tctl[B_DIR]) begin
        if (cnt == '0) begin
          next_cnt = tarr;
          upd      = 1'b1;
        end else next_cnt = cnt - CNT_W'(1);
      end else begin
        if (cnt >= tarr) begin
          next_cnt = '0;
          upd      = 1'b1;
        end else next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0; cdn <= 1'b0; trgo_o <= 1'b0; dma_req_o <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      cdn       <= next_cdn;
      trgo_o    <= upd;
      dma_req_o <= upd & tie;
    end
  end

  // flags: bit 0 update, bit 1+i channel i; write one to clear, set wins
  logic [NUM_CH:0] tset, tclr;
  assign tset = {cap_ev | cmp_ev, upd};
  assign tclr = wr_at(A_TSTAT) ? (NUM_CH+1)'(wb_dat_i) : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) tstat <= '0;
    else tstat <= (tstat & ~tclr) | tset;
  end

  logic [NUM_CH-1:0] oc_d;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [7:0] A_CC = 8'(A_TCC0 + A_TCCSTEP * gi);
      logic [1:0] md;
      logic       cap_src;
      assign md = tmode[2*gi +: 2];
      // channel 0 in Hall mode captures on any change of the sensor xor
      if (gi == 0) begin : g_hall
        assign cap_src = tctl[B_HALL] ? ((^ch_s2) != (^ch_s3))
                                      : (ch_s2[0] & ~ch_s3[0]);
      end else begin : g_edge
        assign cap_src = ch_s2[gi] & ~ch_s3[gi];
      end
      assign cap_ev[gi] = run && (md == CM_CAP) && cap_src && !tctl[B_ENC];
      assign cmp_ev[gi] = step && (md != CM_CAP) && (next_cnt == ccr[gi]);
      always_ff @(posedge clk_i) begin
        if (rst_i) ccr[gi] <= '0;
        else if (cap_ev[gi]) ccr[gi] <= cnt;
        else if (wr_at(A_CC)) ccr[gi] <= CNT_W'(merge(32'(ccr[gi]), wb_dat_i, wb_sel_i));
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) oc_ref[gi] <= 1'b0;
        else begin
          case (md)
            CM_CMP:  oc_ref[gi] <= oc_ref[gi] ^ cmp_ev[gi];
            // ccr 0 gives 0 %, ccr above the reload value gives 100 %
            CM_PWM:  oc_ref[gi] <= next_cnt < ccr[gi];
            CM_OPP:  oc_ref[gi] <= tctl[B_EN] && (next_cnt >= ccr[gi]) && !upd;
            default: oc_ref[gi] <= 1'b0;
          endcase
        end
      end
      if (gi < 3) begin : g_comp
        // both legs held low while the dead-time count runs
        logic [7:0] dcnt;
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            oc_d[gi] <= 1'b0; dcnt <= 8'h0; ch_out_o[gi] <= 1'b0; chn_out_o[gi] <= 1'b0;
          end else begin
            oc_d[gi] <= oc_ref[gi];
            if (oc_ref[gi] != oc_d[gi]) dcnt <= tdt[7:0];
            else if (dcnt != 8'h0) dcnt <= dcnt - 8'h1;
            ch_out_o[gi]  <= tdt[B_MOE] && oc_d[gi] && (dcnt == 8'h0)
                             && (oc_ref[gi] == oc_d[gi]);
            chn_out_o[gi] <= tdt[B_MOE] && !oc_d[gi] && (dcnt == 8'h0)
                             && (oc_ref[gi] == oc_d[gi]) && (md != CM_CAP);
          end
        end
      end else begin : g_plain
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            oc_d[gi] <= 1'b0; ch_out_o[gi] <= 1'b0;
          end else begin
            oc_d[gi] <= oc_ref[gi];
            ch_out_o[gi] <= oc_ref[gi];
          end
        end
      end
    end
    for (gi = NUM_CH; gi < 3; gi++) begin : g_nocomp
      assign chn_out_o[gi] = 1'b0;
    end
  endgenerate

  // ---------------- basic timer ----------------
  logic [2:0]  bctl;
  logic [15:0] bpsc, barr, bpcnt, bcnt;
  logic        brun, btick, bupd, bstat;
  assign brun  = bctl[B_BEN] && !(bctl[B_BFRZ] && dbg_halt_i);
  assign btick = brun && (bpcnt >= bpsc);
  assign bupd  = btick && (bcnt >= barr);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bctl <= 3'h0; bpsc <= 16'h0; barr <= 16'hFFFF; bpcnt <= 16'h0; bcnt <= 16'h0;
      bstat <= 1'b0; dac_trig_o <= 1'b0; bdma_req_o <= 1'b0;
    end else begin
      if (wr_at(A_BCTL)) bctl <= 3'(merge(32'(bctl), wb_dat_i, wb_sel_i));
      if (wr_at(A_BPSC)) bpsc <= 16'(merge(32'(bpsc), wb_dat_i, wb_sel_i));
      if (wr_at(A_BARR)) barr <= 16'(merge(32'(barr), wb_dat_i, wb_sel_i));
      if (brun) bpcnt <= btick ? 16'h0 : bpcnt + 16'h1;
      if (bupd) bcnt <= 16'h0;
      else if (btick) bcnt <= bcnt + 16'h1;
      bstat      <= (bstat & ~(wr_at(A_BSTAT) & wb_dat_i[0])) | bupd;
      dac_trig_o <= bupd;
      bdma_req_o <= bupd & bctl[B_BDMA];
    end
  end

  // ---------------- independent watchdog ----------------
  // counts slow-clock edges only; in a real part this logic sits in an
  // always-on domain so it keeps running when the main clock is stopped
  logic [20:0] icfg;
  logic [7:0]  ipcnt;
  logic [11:0] icnt;
  logic        irun, itof, ifire, strap_done, lsi_tick, istart, ireload;
  logic [1:0]  rel_cnt;
  assign lsi_tick = lsi_s2 & ~lsi_s3;
  assign istart   = wr_at(A_IKEY) && (wb_dat_i[15:0] == KEY_START) && (&wb_sel_i[1:0]);
  assign ireload  = wr_at(A_IKEY) && (wb_dat_i[15:0] == KEY_RELOAD) && (&wb_sel_i[1:0]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icfg <= ICFG_RST; ipcnt <= 8'h0; icnt <= 12'hFFF; irun <= 1'b0; itof <= 1'b0;
      ifire <= 1'b0; strap_done <= 1'b0; rel_cnt <= 2'h0;
    end else begin
      if (wr_at(A_ICFG) && !irun) icfg <= 21'(merge(32'(icfg), wb_dat_i, wb_sel_i));
      // strap sampled once, after the synchroniser has filled
      if (!strap_done) begin
        rel_cnt <= rel_cnt + 2'h1;
        if (rel_cnt == 2'h2) begin
          strap_done <= 1'b1;
          irun       <= irun | strap_s2;
        end
      end
      if (istart) irun <= 1'b1;
      if (ireload || istart) begin
        icnt  <= icfg[ICFG_REL_LSB +: 12];
        ipcnt <= 8'h0;
      end else if (irun && lsi_tick) begin
        if (ipcnt >= icfg[ICFG_PSC_LSB +: 8]) begin
          ipcnt <= 8'h0;
          if (icnt == 12'h0) begin
            if (icfg[B_ITMO]) icnt <= icfg[ICFG_REL_LSB +: 12];
            else ifire <= 1'b1;
          end else icnt <= icnt - 12'h1;
        end else ipcnt <= ipcnt + 8'h1;
      end
      itof <= (itof & ~(wr_at(A_ISTAT) & wb_dat_i[0]))
              | (irun && lsi_tick && icfg[B_ITMO] && icnt == 12'h0
                 && ipcnt >= icfg[ICFG_PSC_LSB +: 8]);
    end
  end

  // ---------------- window watchdog ----------------
  logic [6:0]  wcnt, wwin;
  logic        wact, wewi, wfrz, wewif, wfire, wtick;
  logic [$clog2(WW_DIV)-1:0] wdiv;
  assign wtick = wact && !(wfrz && dbg_halt_i)
                 && (wdiv == ($clog2(WW_DIV))'(WW_DIV - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcnt <= W_CNT_RST; wwin <= W_WIN_RST; wact <= 1'b0; wewi <= 1'b0; wfrz <= 1'b0;
      wewif <= 1'b0; wfire <= 1'b0; wdiv <= '0;
    end else begin
      if (wact && !(wfrz && dbg_halt_i))
        wdiv <= wtick ? '0 : wdiv + ($clog2(WW_DIV))'(1);
      if (wr_at(A_WCFG) && wb_sel_i[0]) {wewi, wwin} <= wb_dat_i[7:0];
      if (wr_at(A_WCFG) && wb_sel_i[1]) wfrz <= wb_dat_i[B_WFRZ];
      if (wr_at(A_WCNT) && wb_sel_i[0]) begin
        // refresh above the window counts as a fault
        if (wact && wcnt > wwin) wfire <= 1'b1;
        wcnt <= wb_dat_i[6:0];
        wact <= wact | wb_dat_i[B_WACT];
      end else if (wtick) begin
        wcnt <= wcnt - 7'h1;
        if (wcnt == W_LAST) wfire <= 1'b1;
      end
      wewif <= (wewif & ~(wr_at(A_WSTAT) & wb_dat_i[0]))
               | (wtick && wcnt == W_EARLY);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_reset_o <= 1'b0; wwdg_ewi_o <= 1'b0;
    end else begin
      dev_reset_o <= ifire | wfire;
      wwdg_ewi_o  <= wewif & wewi;
    end
  end

  // ---------------- tick counter ----------------
  logic [2:0]  kctl;
  logic [23:0] kload, kval;
  logic        kflag, kstep, kzero;
  logic [$clog2(KREF_DIV)-1:0] kdiv;
  assign kstep = kctl[B_KEN] && (kctl[B_KSRC] || (&kdiv));
  assign kzero = kstep && (kval == 24'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kctl <= 3'h0; kload <= 24'h0; kval <= 24'h0; kflag <= 1'b0; kdiv <= '0;
      tick_irq_o <= 1'b0;
    end else begin
      kdiv <= kdiv + ($clog2(KREF_DIV))'(1);
      if (wr_at(A_KCTL)) kctl <= 3'(merge(32'(kctl), wb_dat_i, wb_sel_i));
      if (wr_at(A_KLOAD)) kload <= 24'(merge(32'(kload), wb_dat_i, wb_sel_i));
      // any write clears the current value, so the next step reloads
      if (wr_at(A_KVAL)) kval <= 24'h0;
      else if (kstep) kval <= (kval == 24'h0) ? kload : kval - 24'h1;
      kflag      <= (kflag & ~(rd_kctl | wr_at(A_KVAL))) | kzero;
      tick_irq_o <= kzero & kctl[B_KINT];
    end
  end

  // ---------------- read mux ----------------
  always_comb begin
    rdata = 32'h0;
    case (wb_adr_i)
      A_TCTL:  rdata = 32'(tctl);
      A_TPSC:  rdata = 32'(tpsc);
      A_TARR:  rdata = 32'(tarr);
      A_TCNT:  rdata = 32'(cnt);
      A_TSTAT: rdata = 32'(tstat);
      A_TMODE: rdata = 32'(tmode);
      A_TDT:   rdata = 32'(tdt);
      A_TIE:   rdata = 32'(tie);
      A_BCTL:  rdata = 32'(bctl);
      A_BPSC:  rdata = 32'(bpsc);
      A_BARR:  rdata = 32'(barr);
      A_BCNT:  rdata = 32'(bcnt);
      A_BSTAT: rdata = 32'(bstat);
      A_ICFG:  rdata = 32'(icfg);
      A_ISTAT: rdata = {15'h0, irun, 3'h0, icnt, itof};
      A_WCNT:  rdata = {24'h0, wact, wcnt};
      A_WCFG:  rdata = {23'h0, wfrz, wewi, wwin};
      A_WSTAT: rdata = 32'(wewif);
      A_KCTL:  rdata = {15'h0, kflag, 13'h0, kctl};
      A_KLOAD: rdata = 32'(kload);
      A_KVAL:  rdata = 32'(kval);
      default: begin
        for (int i = 0; i < NUM_CH; i++)
          if (wb_adr_i == 8'(A_TCC0 + A_TCCSTEP * i)) rdata = 32'(ccr[i]);
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== shared/tw_pkg.sv ====
// register map, field positions, reset values and counts of the timer family
package tw_pkg;
  // full-featured timer
  localparam logic [7:0] A_TCTL  = 8'h00;
  localparam logic [7:0] A_TPSC  = 8'h04;
  localparam logic [7:0] A_TARR  = 8'h08;
  localparam logic [7:0] A_TCNT  = 8'h0C;
  localparam logic [7:0] A_TSTAT = 8'h10;
  localparam logic [7:0] A_TMODE = 8'h14;
  localparam logic [7:0] A_TDT   = 8'h18;
  localparam logic [7:0] A_TIE   = 8'h1C;
  localparam logic [7:0] A_TCC0  = 8'h20;
  localparam logic [7:0] A_TCCSTEP = 8'h04;
  // basic timer
  localparam logic [7:0] A_BCTL  = 8'h30;
  localparam logic [7:0] A_BPSC  = 8'h34;
  localparam logic [7:0] A_BARR  = 8'h38;
  localparam logic [7:0] A_BCNT  = 8'h3C;
  localparam logic [7:0] A_BSTAT = 8'h40;
  // independent watchdog
  localparam logic [7:0] A_IKEY  = 8'h44;
  localparam logic [7:0] A_ICFG  = 8'h48;
  localparam logic [7:0] A_ISTAT = 8'h4C;
  // window watchdog
  localparam logic [7:0] A_WCNT  = 8'h50;
  localparam logic [7:0] A_WCFG  = 8'h54;
  localparam logic [7:0] A_WSTAT = 8'h58;
  // tick counter
  localparam logic [7:0] A_KCTL  = 8'h5C;
  localparam logic [7:0] A_KLOAD = 8'h60;
  localparam logic [7:0] A_KVAL  = 8'h64;

  // TCTL bits
  localparam int B_EN   = 0;
  localparam int B_DIR  = 1;
  localparam int B_CMS  = 2;
  localparam int B_OPM  = 3;
  localparam int B_ENC  = 4;
  localparam int B_HALL = 5;
  localparam int B_FRZ  = 6;
  localparam int B_SLV  = 7;
  localparam int TCTL_W = 8;
  // TDT bits
  localparam int B_MOE  = 8;
  // TIE bits
  localparam int B_DMA  = 0;
  // BCTL bits
  localparam int B_BEN  = 0;
  localparam int B_BFRZ = 1;
  localparam int B_BDMA = 2;
  // ICFG fields
  localparam int ICFG_PSC_LSB = 0;
  localparam int ICFG_REL_LSB = 8;
  localparam int B_ITMO       = 20;
  localparam logic [20:0] ICFG_RST = 21'h0FFF00;
  localparam logic [15:0] KEY_START  = 16'hCCCC;
  localparam logic [15:0] KEY_RELOAD = 16'hAAAA;
  // WCNT / WCFG
  localparam int B_WACT = 7;
  localparam int B_WEWI = 7;
  localparam int B_WFRZ = 8;
  localparam logic [6:0] W_CNT_RST = 7'h7F;
  localparam logic [6:0] W_WIN_RST = 7'h7F;
  localparam logic [6:0] W_EARLY   = 7'h41;
  localparam logic [6:0] W_LAST    = 7'h40;
  // KCTL bits
  localparam int B_KEN  = 0;
  localparam int B_KINT = 1;
  localparam int B_KSRC = 2;
  localparam int B_KFLG = 16;
  localparam int KREF_DIV = 8;

  // channel modes, two bits per channel in TMODE
  localparam logic [1:0] CM_CAP = 2'h0;
  localparam logic [1:0] CM_CMP = 2'h1;
  localparam logic [1:0] CM_PWM = 2'h2;
  localparam logic [1:0] CM_OPP = 2'h3;
endpackage

// ==== sim/tw_props.sv ====
// port checker for the timer family
`timescale 1ns/100ps
`default_nettype none
module tw_props #(
  parameter int NUM_CH = 4
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic [NUM_CH-1:0] ch_out_o,
  input wire logic [2:0]        chn_out_o,
  input wire logic              trgo_o,
  input wire logic              dma_req_o,
  input wire logic              dac_trig_o,
  input wire logic              tick_irq_o,
  input wire logic              dev_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_answer: assert property (s_req |=> s_ack_once)
    else $error("request not answered by a single ack");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_legs_apart: assert property ((ch_out_o[2:0] & chn_out_o) == 3'h0)
    else $error("both legs of a pair high");
  a_reset_sticky: assert property (dev_reset_o |=> dev_reset_o)
    else $error("device reset request dropped");
  a_update_pulse: assert property (trgo_o |=> !trgo_o)
    else $error("update pulse too long");
  a_dma_pulse: assert property ($rose(dma_req_o) |=> $fell(dma_req_o))
    else $error("dma request too long");
  a_dac_pulse: assert property (dac_trig_o |=> !dac_trig_o)
    else $error("converter trigger too long");
  a_tick_pulse: assert property (tick_irq_o |=> !tick_irq_o)
    else $error("tick interrupt too long");
endmodule
bind tw_timer_family tw_props #(.NUM_CH(NUM_CH)) tw_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .ch_out_o(ch_out_o), .chn_out_o(chn_out_o), .trgo_o(trgo_o),
  .dma_req_o(dma_req_o), .dac_trig_o(dac_trig_o), .tick_irq_o(tick_irq_o),
  .dev_reset_o(dev_reset_o));
`default_nettype wire

// ==== sim/tw_pins.sv ====
// pin-side model: quadrature encoder and free slow oscillator
`timescale 1ns/100ps
`default_nettype none
module tw_pins (
  input  wire logic       clk_i,
  input  wire logic       enc_en_i,
  output logic      [3:0] ch_o,
  output logic            lsi_o,
  output int              edges_o
);
  logic [1:0] ph = 2'h0;
  logic [4:0] div = 5'h00;
  initial edges_o = 0;
  // oscillator runs free, unrelated to any frame
  always @(posedge clk_i) begin
    div <= div + 5'h01;
    if (enc_en_i && div[2:0] == 3'h7) begin
      ph <= ph + 2'h1;
      if (!ph[0]) edges_o <= edges_o + 1;
    end
  end
  assign ch_o = {2'h0, ph[1], ph[0] ^ ph[1]};
  assign lsi_o = div[4];
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the timer family
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tw_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg = 1'b0, enc = 1'b0;
  logic        trg = 1'b0, strap = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [31:0] seed = 32'h3A;
  logic [3:0]  ch_in, ch_out;
  logic [2:0]  chn;
  logic [4:0]  ev;
  logic        ack, trgo, dma, dac, bdma, lsi, devr, ewi, tick;
  int          err_count = 0, comparisons = 0, edges, a, b, t;
  int          ctl[3] = '{1, 3, 5};
  int          per[3] = '{10, 10, 9};
  assign ev = {dma, bdma, trgo, tick, dac};
  always #10 clk_i = ~clk_i;
  tw_timer_family #(.WW_DIV(4)) tw_timer_family_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .dbg_halt_i(dbg), .ch_in_i(ch_in), .ch_out_o(ch_out), .chn_out_o(chn),
    .trig_in_i(trg), .trgo_o(trgo), .dma_req_o(dma), .dac_trig_o(dac),
    .bdma_req_o(bdma), .lsi_i(lsi), .iwdg_hw_start_i(strap), .dev_reset_o(devr),
    .wwdg_ewi_o(ewi), .tick_irq_o(tick));
  tw_pins tw_pins_i (.clk_i(clk_i), .enc_en_i(enc), .ch_o(ch_in), .lsi_o(lsi),
    .edges_o(edges));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'h3, w, ad, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  // period between two pulses of the chosen event
  task automatic gap(input int s, output int n);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ev[s] !== 1'b1 && n < 2000);
    end
  endtask
  task automatic rst();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    summarize();
  end
  initial begin
    rst();
    wb(0, A_TARR, 0); chk(q, 32'hFFFFFFFF);
    wb(0, A_BARR, 0); chk(q, 32'h0000FFFF);
    wb(0, A_ICFG, 0); chk(q, {11'h0, ICFG_RST});
    wb(0, A_WCNT, 0); chk(q, {25'h0, W_CNT_RST});
    wb(0, 8'hFC, 0); chk(q, 32'h0);
    $display("registers done");
    a = int'(xs() & 32'hF) + 2;
    b = int'(xs() & 32'h3);
    wb(1, A_BARR, a); wb(1, A_BPSC, b); wb(1, A_BCTL, 32'h5);
    gap(0, t); chk(t, (a + 1) * (b + 1));
    gap(3, t); chk(t, (a + 1) * (b + 1));
    wb(1, A_BCTL, 32'h3); dbg <= 1'b1;
    wb(0, A_BCNT, 0); t = q;
    repeat (90) @(posedge clk_i);
    wb(0, A_BCNT, 0); chk(q, t);
    dbg <= 1'b0;
    a = int'(xs() & 32'hFF) + 4;
    wb(1, A_KLOAD, a); wb(1, A_KCTL, 32'h7);
    gap(1, t); chk(t, a + 1);
    wb(1, A_KCTL, 32'h5);
    gap(1, t); chk(t, 2000);
    $display("basic and tick done");
    rst();
    wb(1, A_TARR, 9); wb(1, A_TDT, 32'h102); wb(1, A_TIE, 1); wb(1, A_TMODE, CM_PWM);
    for (b = 0; b < 2; b++) begin
      wb(1, A_TCC0, b * 10); wb(1, A_TCTL, 1);
      repeat (40) @(posedge clk_i);
      repeat (30) begin
        @(posedge clk_i);
        chk({ch_out, chn}, b ? 7'h08 : 7'h01);
      end
    end
    for (b = 0; b < 3; b++) begin
      wb(1, A_TCTL, ctl[b]);
      gap(2, t); chk(t, per[b]);
    end
    gap(4, t); chk(t, per[2]);
    // long reload so no overflow update meets the trigger
    wb(1, A_TARR, 1000); wb(1, A_TCTL, 32'h81);
    @(posedge clk_i);
    trg <= 1'b1;
    @(posedge clk_i);
    trg <= 1'b0;
    wb(0, A_TCNT, 0); chk(q, 1);
    $display("pwm done");
    rst();
    wb(1, A_TCTL, 32'h11); enc <= 1'b1;
    repeat (200) @(posedge clk_i);
    enc <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(0, A_TCNT, 0); chk(q, edges);
    wb(1, A_ICFG, 32'h100200); wb(1, A_IKEY, KEY_START);
    repeat (600) @(posedge clk_i);
    wb(0, A_ISTAT, 0); chk({q[0], devr}, 2'h2);
    wb(1, A_WCFG, 32'hFF); wb(1, A_WCNT, 32'hC2);
    {a, b} = 0;
    for (t = 1; t < 200 && b == 0; t++) begin
      @(posedge clk_i);
      if (ewi === 1'b1 && a == 0) a = t;
      if (devr === 1'b1) b = t;
    end
    chk(a > 0 && b > a && b - a <= 10, 1);
    // strap is sampled a few edges after release
    strap <= 1'b1;
    rst();
    repeat (4) @(posedge clk_i);
    wb(0, A_ISTAT, 0); chk({q[16], devr}, 2'h2);
    $display("pins and watchdogs done");
    summarize();
  end
endmodule
`default_nettype wire
